/* File: include/dbx_pkg.sv */
// Package for the debug exception logic: register map, field layout, vectors.
// Assumes a single core clock and a plain register port from core software.
package dbx_pkg;

  localparam logic [7:0]  OPC_BKPT1    = 8'hcc;
  localparam logic [7:0]  OPC_INTN     = 8'hcd;
  localparam logic [7:0]  VEC_STEP     = 8'h01;
  localparam logic [7:0]  VEC_BKPT     = 8'h03;
  localparam logic [7:0]  VEC_GP       = 8'h0d;
  localparam int          STEP_BIT     = 8;
  localparam int          NUM_BP       = 4;

  // Register indices (word addresses)
  localparam logic [3:0]  ADDR_BP0     = 4'h0;
  localparam logic [3:0]  ADDR_BP3     = 4'h3;
  localparam logic [3:0]  ADDR_STATUS  = 4'h6;
  localparam logic [3:0]  ADDR_CTRL    = 4'h7;
  localparam logic [3:0]  ADDR_IRQ_ST  = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_MSK = 4'h9;

  // Control register layout
  localparam int          CTRL_EN_LSB  = 0;
  localparam int          CTRL_RW_LSB  = 16;
  localparam int          CTRL_RW_W    = 2;
  localparam int          CTRL_LEN_LSB = 18;
  localparam int          CTRL_FLD_STR = 4;

  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam int          ST_STEP_BIT  = 14;

  // Field encodings
  localparam logic [1:0]  LEN_BYTE     = 2'h0;
  localparam logic [1:0]  LEN_WORD     = 2'h1;
  localparam logic [1:0]  LEN_DWORD    = 2'h3;
  localparam logic [1:0]  RW_EXEC      = 2'h0;
  localparam logic [1:0]  RW_WRITE     = 2'h1;
  localparam logic [1:0]  RW_RDWR      = 2'h3;

  // Interrupt status bits
  localparam int          IRQ_STEP     = 0;
  localparam int          IRQ_BKPT     = 1;
  localparam int          IRQ_BP_FLT   = 2;
  localparam int          IRQ_BP_TRAP  = 3;
  localparam int          IRQ_W        = 4;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        is_fetch;
    logic        is_write;
  } dbx_access_t;

  typedef struct packed {
    logic        done;
    logic [7:0]  opcode;
    logic [7:0]  operand;
    logic [31:0] next_ip;
    logic [31:0] flags;
    logic        prot_mode;
    logic        v86_mode;
    logic [1:0]  cpl;
    logic [1:0]  io_privilege_level;
  } dbx_retire_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  vector;
    logic        is_fault;
    logic [31:0] return_ip;
  } dbx_exc_t;

endpackage : dbx_pkg

/* File: rtl/dbx_bp_compare.sv */
// One breakpoint comparator: address window plus access qualifier.
// Assumes access information arrives already registered in the core clock.
`timescale 1ns/100ps
`default_nettype none
module dbx_bp_compare (
  // Breakpoint setup
  input  wire logic [31:0]          bp_addr,
  input  wire logic [1:0]           size_field,
  input  wire logic [1:0]           access_qualifier_field,
  input  wire logic                 armed,
  // Access under test
  input  wire dbx_pkg::dbx_access_t acc,
  // Result
  output logic                      hit
);
  import dbx_pkg::*;

  logic [31:0] mask;
  logic        kind_ok;

  always_comb begin
    case (size_field)
      LEN_WORD:  mask = 32'hffff_fffe;
      LEN_DWORD: mask = 32'hffff_fffc;
      default:   mask = 32'hffff_ffff;
    endcase
    case (access_qualifier_field)
      RW_EXEC:  kind_ok = acc.is_fetch;
      RW_WRITE: kind_ok = !acc.is_fetch && acc.is_write;
      RW_RDWR:  kind_ok = !acc.is_fetch;
      default:  kind_ok = 1'b0;
    endcase
  end

  // Compare only, memory never patched
  assign hit = armed && acc.valid && kind_ok && ((acc.addr & mask) == (bp_addr & mask));

endmodule : dbx_bp_compare
`default_nettype wire

/* File: rtl/dbx_step_track.sv */
// Single-step tracker: decides when a step trap is due at retirement.
// Assumes one retire pulse per completed instruction.
`timescale 1ns/100ps
`default_nettype none
module dbx_step_track (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  // Retirement
  input  wire logic retire,
  input  wire logic step_flag_now,
  // Result
  output logic      step_due
);
  import dbx_pkg::*;

  logic step_armed_reg;

  // Flag is taken as seen before the retiring instruction began
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      step_armed_reg <= 1'b0;
    end else if (clk_en && retire) begin
      step_armed_reg <= step_flag_now;
    end
  end

  // Instruction that sets the flag retires before the trap can fire
  assign step_due = retire && step_armed_reg;

endmodule : dbx_step_track
`default_nettype wire

/* File: rtl/dbx_debug_unit.sv */
// Debug exception logic: breakpoint opcode, single step, debug registers.
// Assumes retire and access strobes come from core logic on core_clk.
`timescale 1ns/100ps
`default_nettype none
module dbx_debug_unit (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 clk_en,
  // Register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  // Core events
  input  wire dbx_pkg::dbx_access_t access,
  input  wire dbx_pkg::dbx_retire_t retire,
  // Exception request
  output dbx_pkg::dbx_exc_t         exc,
  output logic                      irq
);
  import dbx_pkg::*;

  logic [31:0]       breakpoint_address_regs [NUM_BP];
  logic [31:0]       breakpoint_control_reg;
  logic [31:0]       breakpoint_status_reg;
  logic [IRQ_W-1:0]  irq_status_reg;
  logic [IRQ_W-1:0]  irq_mask_reg;
  logic [IRQ_W-1:0]  irq_event;
  logic [NUM_BP-1:0] hit;
  logic [NUM_BP-1:0] trap_hit_reg;
  logic              fetch_hit;
  logic              data_hit;
  logic              step_due;
  logic              bkpt_op;
  logic              intn_op;
  logic              intn_gp;
  logic              single_step_flag;
  logic              wr_bp;
  dbx_exc_t          exc_next;

  assign single_step_flag = retire.flags[STEP_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BP; gi++) begin : g_bp
      logic system_wide_enable;
      logic task_local_enable;
      assign task_local_enable  = breakpoint_control_reg[CTRL_EN_LSB + 2*gi];
      assign system_wide_enable = breakpoint_control_reg[CTRL_EN_LSB + 2*gi + 1];
      dbx_bp_compare u_cmp (
        .bp_addr                (breakpoint_address_regs[gi]),
        .size_field             (breakpoint_control_reg[CTRL_LEN_LSB + CTRL_FLD_STR*gi +: 2]),
        .access_qualifier_field (breakpoint_control_reg[CTRL_RW_LSB + CTRL_FLD_STR*gi +: 2]),
        .armed                  (system_wide_enable || task_local_enable),
        .acc                    (access),
        .hit                    (hit[gi])
      );
    end
  endgenerate

  assign fetch_hit = |hit && access.is_fetch;
  assign data_hit  = |hit && !access.is_fetch;

  dbx_step_track u_step (
    .core_clk      (core_clk),
    .reset         (reset),
    .clk_en        (clk_en),
    .retire        (retire.done),
    .step_flag_now (single_step_flag),
    .step_due      (step_due)
  );

  // One-byte and two-byte forms share the vector-3 path
  assign bkpt_op = retire.done && ((retire.opcode == OPC_BKPT1) ||
                   (retire.opcode == OPC_INTN && retire.operand == VEC_BKPT));
  assign intn_op = retire.done && retire.opcode == OPC_INTN;
  // Only the two-byte form is privilege checked
  assign intn_gp = intn_op && (retire.prot_mode || retire.v86_mode) &&
                   (retire.cpl > retire.io_privilege_level);

  assign wr_bp = clk_en && reg_wr && reg_addr <= ADDR_BP3;

  // Debug address registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_BP; i++) begin
        breakpoint_address_regs[i] <= 32'h0000_0000;
      end
    end else if (wr_bp) begin
      breakpoint_address_regs[reg_addr[1:0]] <= reg_wdata;
    end
  end

  // Control register: all enables clear from reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      breakpoint_control_reg <= CTRL_RESET;
    end else if (clk_en && reg_wr && reg_addr == ADDR_CTRL) begin
      breakpoint_control_reg <= reg_wdata;
    end
  end

  // Data hits held until the instruction completes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      trap_hit_reg <= '0;
    end else if (clk_en) begin
      if (retire.done) begin
        trap_hit_reg <= data_hit ? hit : '0;
      end else if (data_hit) begin
        trap_hit_reg <= trap_hit_reg | hit;
      end
    end
  end

  // Status: software writes, hardware hits set bits and win
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      breakpoint_status_reg <= STATUS_RESET;
    end else if (clk_en) begin
      logic [31:0] st;
      st = breakpoint_status_reg;
      if (reg_wr && reg_addr == ADDR_STATUS) begin
        st = reg_wdata;
      end
      if (fetch_hit) begin
        st[NUM_BP-1:0] = st[NUM_BP-1:0] | hit;
      end
      if (retire.done) begin
        st[NUM_BP-1:0] = st[NUM_BP-1:0] | trap_hit_reg;
      end
      if (step_due) begin
        st[ST_STEP_BIT] = 1'b1;
      end
      breakpoint_status_reg <= st;
    end
  end

  // Priority: execute fault first, then general-protection, then traps
  always_comb begin
    exc_next = '0;
    if (fetch_hit) begin
      exc_next.valid     = 1'b1;
      exc_next.vector    = VEC_STEP;
      exc_next.is_fault  = 1'b1;
      exc_next.return_ip = access.addr;
    end else if (intn_gp) begin
      exc_next.valid     = 1'b1;
      exc_next.vector    = VEC_GP;
      exc_next.is_fault  = 1'b1;
      exc_next.return_ip = retire.next_ip;
    end else if (retire.done && (step_due || |trap_hit_reg)) begin
      exc_next.valid     = 1'b1;
      exc_next.vector    = VEC_STEP;
      exc_next.return_ip = retire.next_ip;
    end else if (bkpt_op) begin
      exc_next.valid     = 1'b1;
      exc_next.vector    = VEC_BKPT;
      exc_next.return_ip = retire.next_ip;
    end else if (intn_op) begin
      exc_next.valid     = 1'b1;
      exc_next.vector    = retire.operand;
      exc_next.return_ip = retire.next_ip;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      exc <= '0;
    end else if (clk_en) begin
      exc <= exc_next;
    end
  end

  assign irq_event[IRQ_STEP]    = step_due;
  assign irq_event[IRQ_BKPT]    = bkpt_op;
  assign irq_event[IRQ_BP_FLT]  = fetch_hit;
  assign irq_event[IRQ_BP_TRAP] = retire.done && |trap_hit_reg;

  // Sticky events: a new event wins over a write-one clear
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_status_reg <= '0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == ADDR_IRQ_ST) begin
        irq_status_reg <= (irq_status_reg & ~reg_wdata[IRQ_W-1:0]) | irq_event;
      end else begin
        irq_status_reg <= irq_status_reg | irq_event;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_mask_reg <= '0;
    end else if (clk_en && reg_wr && reg_addr == ADDR_IRQ_MSK) begin
      irq_mask_reg <= reg_wdata[IRQ_W-1:0];
    end
  end

  // Registered output lags status by one cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          4'h0, 4'h1, 4'h2, 4'h3: reg_rdata <= breakpoint_address_regs[reg_addr[1:0]];
          ADDR_STATUS:  reg_rdata <= breakpoint_status_reg;
          ADDR_CTRL:    reg_rdata <= breakpoint_control_reg;
          ADDR_IRQ_ST:  reg_rdata <= {{(32-IRQ_W){1'b0}}, irq_status_reg};
          ADDR_IRQ_MSK: reg_rdata <= {{(32-IRQ_W){1'b0}}, irq_mask_reg};
          default:      reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : dbx_debug_unit
`default_nettype wire

/* File: dv/dbx_debug_unit_props.sv */
// Port checker for the debug exception unit, bound to its top module.
// Assumes clk_en drops only while no exception or read data is showing.
`timescale 1ns/100ps
`default_nettype none
module dbx_debug_unit_props (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 reset,
  input wire logic                 clk_en,
  // Register port
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata,
  // Core events and result
  input wire dbx_pkg::dbx_access_t access,
  input wire dbx_pkg::dbx_retire_t retire,
  input wire dbx_pkg::dbx_exc_t    exc
);
  import dbx_pkg::*;
  logic step_arm_reg;
  logic acc_seen_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Flag as left by the last retired instruction
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) step_arm_reg <= 1'b0;
    else if (clk_en && retire.done) step_arm_reg <= retire.flags[STEP_BIT];
  end
  // Any access since the last retire may leave a data hit pending
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) acc_seen_reg <= 1'b0;
    else if (clk_en) acc_seen_reg <= retire.done ? access.valid : (acc_seen_reg | access.valid);
  end
  property p_bkpt_vec;
    exc.valid && exc.vector == VEC_BKPT |-> $past(retire.done) && !exc.is_fault &&
      exc.return_ip == $past(retire.next_ip) && ($past(retire.opcode) == OPC_BKPT1 ||
      $past(retire.opcode) == OPC_INTN && $past(retire.operand) == VEC_BKPT);
  endproperty
  a_bkpt_vec: assert property (p_bkpt_vec) else $error("bad vector 3 exception");
  property p_bkpt_any;
    clk_en && retire.done && retire.opcode == OPC_BKPT1 |=> exc.valid && exc.vector != VEC_GP;
  endproperty
  a_bkpt_any: assert property (p_bkpt_any) else $error("breakpoint opcode lost");
  property p_gp;
    clk_en && retire.done && retire.opcode == OPC_INTN && !access.valid &&
      (retire.prot_mode || retire.v86_mode) && retire.cpl > retire.io_privilege_level
      |=> exc.valid && exc.vector == VEC_GP;
  endproperty
  a_gp: assert property (p_gp) else $error("privilege check missed");
  property p_step;
    clk_en && retire.done && step_arm_reg && !access.valid && retire.opcode != OPC_INTN
      |=> exc.valid && exc.vector == VEC_STEP && !exc.is_fault &&
      exc.return_ip == $past(retire.next_ip);
  endproperty
  a_step: assert property (p_step) else $error("single step trap wrong");
  property p_quiet;
    clk_en && retire.done && !step_arm_reg && !acc_seen_reg && !access.valid &&
      retire.opcode != OPC_BKPT1 && retire.opcode != OPC_INTN |=> !exc.valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("exception without cause");
  property p_exec_fault;
    exc.valid && exc.is_fault |-> (exc.vector == VEC_GP && $past(retire.done)) ||
      (exc.vector == VEC_STEP && $past(access.valid) &&
      $past(access.is_fetch) && exc.return_ip == $past(access.addr));
  endproperty
  a_exec_fault: assert property (p_exec_fault) else $error("bad fault");
  property p_data_trap;
    exc.valid && exc.vector == VEC_STEP && !exc.is_fault |-> $past(retire.done) &&
      exc.return_ip == $past(retire.next_ip);
  endproperty
  a_data_trap: assert property (p_data_trap) else $error("bad trap");
  property p_rdata;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
  c_step: cover property (exc.valid && exc.vector == VEC_STEP && !exc.is_fault);
  c_fault: cover property (exc.valid && exc.is_fault);
  c_gp: cover property (exc.valid && exc.vector == VEC_GP);
endmodule : dbx_debug_unit_props
bind dbx_debug_unit dbx_debug_unit_props i_dbx_debug_unit_props (.core_clk(core_clk),
  .reset(reset), .clk_en(clk_en), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .access(access), .retire(retire), .exc(exc));
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the debug exception unit.
// Assumes package and checker are compiled before it; clk_en stays high except around the final mask write.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dbx_pkg::*;
  logic        core_clk  = 1'b0;
  logic        reset     = 1'b1;
  logic        clk_en    = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  dbx_access_t access    = '0;
  dbx_retire_t retire    = '0;
  dbx_exc_t    exc;
  logic        irq;
  int          mismatches = 0;
  int          compares   = 0;
  logic [31:0] nip;
  logic [31:0] base;
  always #20 core_clk = ~core_clk;
  dbx_debug_unit i_dbx_debug_unit (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .access(access), .retire(retire), .exc(exc), .irq(irq));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  function automatic logic [7:0] exp_vec(input logic [7:0] opr, input logic [1:0] m, cpl);
    return (m != 2'b00 && cpl != 2'h0) ? VEC_GP : opr;
  endfunction : exp_vec
  task automatic xchk(input logic v, input logic [7:0] vec, input logic f, input logic [31:0] ip);
    #1;
    if (v) chk(exc, {v, vec, f, ip});
    else chk(exc.valid, 1'b0);
  endtask : xchk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic acc(input logic [31:0] a, input logic f, w);
    @(posedge core_clk);
    access <= '{1'b1, a, f, w};
    @(posedge core_clk);
    access.valid <= 1'b0;
  endtask : acc
  // Retire one instruction; m is {protected, v86}; io privilege level is 0
  task automatic ret(input logic [7:0] opc, opr, input logic fl, input logic [1:0] m, cpl,
                     input logic v, input logic [7:0] vec);
    nip = $urandom;
    @(posedge core_clk);
    retire <= '{1'b1, opc, opr, nip, {23'h0, fl, 8'h0}, m[1], m[0], cpl, 2'h0};
    @(posedge core_clk);
    retire.done <= 1'b0;
    // Only the privilege refusal of the two-byte form is a fault
    xchk(v, vec, opc == OPC_INTN && m != 2'b00 && cpl != 2'h0, nip);
  endtask : ret
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  len;
    logic [1:0]  rw;
    int          i;
    void'($urandom(32'h0955a79a));
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(ADDR_CTRL, d); chk(d, CTRL_RESET);
    rd(ADDR_STATUS, d); chk(d, STATUS_RESET);
    rd(4'hf, d); chk(d, 32'h0);
    ret(8'h90, 8'h00, 1'b0, 2'b00, 2'h0, 1'b0, 8'h0);
    for (i = 0; i < 4; i++) begin
      base = $urandom;
      wr(4'(i), base);
      rd(4'(i), d); chk(d, base);
    end
    wr(ADDR_IRQ_ST, 32'hf);
    wr(ADDR_IRQ_MSK, 32'(1 << IRQ_BKPT));
    ret(OPC_BKPT1, 8'h00, 1'b0, 2'b10, 2'h3, 1'b1, VEC_BKPT);
    repeat (2) @(posedge core_clk);
    #1 chk(irq, 1'b1);
    wr(ADDR_IRQ_ST, 32'(1 << IRQ_BKPT));
    @(posedge core_clk);
    #1 chk(irq, 1'b0);
    wr(ADDR_IRQ_MSK, 32'h0);
    ret(OPC_INTN, VEC_BKPT, 1'b0, 2'b00, 2'h0, 1'b1, VEC_BKPT);
    for (i = 0; i < 6; i++) begin
      d = $urandom;
      ret(OPC_INTN, d[7:0], 1'b0, 2'(i % 3), 2'(i / 3 * 3), 1'b1,
          exp_vec(d[7:0], 2'(i % 3), 2'(i / 3 * 3)));
      ret(OPC_BKPT1, d[7:0], 1'b0, 2'(i % 3), 2'(i / 3 * 3), 1'b1, VEC_BKPT);
    end
    #1 chk(irq, 1'b0);
    // Flag set twice in a row: the step trap outranks the breakpoint opcode
    ret(8'h90, 8'h00, 1'b1, 2'b00, 2'h0, 1'b0, 8'h0);
    ret(OPC_BKPT1, 8'h00, 1'b1, 2'b00, 2'h0, 1'b1, VEC_STEP);
    ret(8'h90, 8'h00, 1'b0, 2'b00, 2'h0, 1'b1, VEC_STEP);
    ret(8'h90, 8'h00, 1'b0, 2'b00, 2'h0, 1'b0, 8'h0);
    base = $urandom;
    wr(ADDR_BP0, base);
    wr(ADDR_CTRL, 32'h2);
    acc(base + 32'h1, 1'b1, 1'b0); xchk(1'b0, 8'h0, 1'b0, 32'h0);
    acc(base, 1'b1, 1'b0); xchk(1'b1, VEC_STEP, 1'b1, base);
    rd(ADDR_STATUS, d); chk(d[0], 1'b1);
    base = $urandom & 32'hffff_fffc;
    wr(ADDR_BP0 + 4'h1, base);
    for (i = 0; i < 6; i++) begin
      len = (i % 3 == 2) ? LEN_DWORD : 2'(i % 3);
      rw = (i < 3) ? RW_WRITE : RW_RDWR;
      wr(ADDR_CTRL, 32'h4 | (32'(rw) << 20) | (32'(len) << 22));
      acc(base + 32'(len), 1'b0, 1'b1);
      ret(8'h90, 8'h00, 1'b0, 2'b00, 2'h0, 1'b1, VEC_STEP);
      acc(base + 32'(len) + 32'h1, 1'b0, 1'b1);
      ret(8'h90, 8'h00, 1'b0, 2'b00, 2'h0, 1'b0, 8'h0);
      acc(base, 1'b0, 1'b0);
      ret(8'h90, 8'h00, 1'b0, 2'b00, 2'h0, rw == RW_RDWR, VEC_STEP);
    end
    wr(ADDR_CTRL, 32'h0);
    acc(base, 1'b0, 1'b1);
    ret(8'h90, 8'h00, 1'b0, 2'b00, 2'h0, 1'b0, 8'h0);
    // Step, vector 3, execute and data events have all been seen by now
    rd(ADDR_IRQ_ST, d); chk(d, 32'hf);
    // Write with the clock enable low must leave the mask untouched
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(ADDR_IRQ_MSK, 32'hf);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd(ADDR_IRQ_MSK, d); chk(d, 32'h0);
    summarize();
  end
endmodule : testbench
`default_nettype wire
